// ### design/spc_pkg.sv
package spc_pkg;
  // Widths
  localparam int PIN_W  = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PAD_W  = DATA_W - PIN_W;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PIN  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DIR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PULL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IOC  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h10;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_GPU_BIT  = 1;

  // Reset values
  localparam logic [PIN_W-1:0] DIR_RST   = 6'h3f;
  localparam logic [PIN_W-1:0] PULL_RST  = 6'h3f;
  localparam logic [PIN_W-1:0] IOC_RST   = 6'h00;
  localparam logic [PIN_W-1:0] LATCH_RST = 6'h00;
  localparam logic             GPU_RST   = 1'b0;

  // Pin masks
  localparam logic [PIN_W-1:0] INPUT_ONLY_MASK = 6'h08;
  localparam logic [PIN_W-1:0] CRYSTAL_MASK    = 6'h30;
  localparam logic [PIN_W-1:0] NO_PINS         = 6'h00;
  localparam logic [PAD_W-1:0] UPPER_ZERO      = 26'h0000000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/spc_sync.sv
module spc_sync (
  // Clock and reset
  input  logic                      clk,
  input  logic                      nrst,
  // Raw and synchronised pins
  input  logic [spc_pkg::PIN_W-1:0] d,
  output logic [spc_pkg::PIN_W-1:0] q
);
  logic [spc_pkg::PIN_W-1:0] stage1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= spc_pkg::NO_PINS;
      q      <= spc_pkg::NO_PINS;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // spc_sync

// ### design/spc_change.sv
module spc_change (
  // Clock and power-on reset
  input  logic                      clk,
  input  logic                      nrst,
  // Pin samples and control
  input  logic [spc_pkg::PIN_W-1:0] pins,
  input  logic [spc_pkg::PIN_W-1:0] enable,
  input  logic                      capture,
  // Result
  output logic                      mismatch
);
  logic [spc_pkg::PIN_W-1:0] lastRead;

  assign mismatch = |((pins ^ lastRead) & enable);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastRead <= spc_pkg::LATCH_RST;
    end else if (capture) begin
      lastRead <= pins;
    end
  end
endmodule // spc_change

// ### design/spc_port.sv
// Overview of operation
// - Pin value bits seven and six always read zero.
// - Pin value read returns each lower pin level, high one, low zero, except pin three while it serves master clear.
// - A pin with analog select set reads zero.
// - Output data latches need no defined power-on value.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero drives the output latch onto the pin.
// - Direction bit three always reads one; pin is input only.
// - Crystal modes force direction bits five and four to read one.
// - Each pin has a pull-up enable bit, one enables.
// - Pull-up switches off while the pin is an output.
// - Pull-ups need the global control; power-on leaves them disabled.
// - Input-only pin pull-up is on when it serves master clear.
// - Crystal modes force pull-up enable bits five and four to read one; those pull-ups stay off.
// - Per-pin change enable bits, cleared by power-on reset.
// - Enabled pins compared with last-read latch; mismatches OR to flag.
// - A port change condition can wake the device from sleep.
// - Pin value access refreshes the latch; software then clears flag.
// - Persisting mismatch keeps setting the flag over software clears.
// - Comparison latch survives master clear and brown-out resets.
// - A change coinciding with a read may be missed.
// - Crystal modes force change enable bits five and four to read one; comparison uses the written bits.
// - Pin value write loads the latch; read returns pin levels.
module spc_port (
  // Clock and power-on reset
  input  logic                       clk,
  input  logic                       nrst,
  // Master clear or brown-out reset, one-cycle pulse
  input  logic                       warmReset,
  // Device configuration
  input  logic                       crystalMode,
  input  logic                       masterClearFunction,
  input  logic [spc_pkg::PIN_W-1:0]  analogSelect,
  // Pins
  input  logic [spc_pkg::PIN_W-1:0]  pinIn,
  output logic [spc_pkg::PIN_W-1:0]  pinOut,
  output logic [spc_pkg::PIN_W-1:0]  pinOutEnN,
  output logic [spc_pkg::PIN_W-1:0]  pullupOn,
  // Events
  output logic                       portChangeFlag,
  output logic                       portChangeWake,
  // AXI4-Lite write
  input  logic [spc_pkg::ADDR_W-1:0] awaddr,
  input  logic                       awvalid,
  output logic                       awready,
  input  logic [spc_pkg::DATA_W-1:0] wdata,
  input  logic [3:0]                 wstrb,
  input  logic                       wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  logic                       bready,
  // AXI4-Lite read
  input  logic [spc_pkg::ADDR_W-1:0] araddr,
  input  logic                       arvalid,
  output logic                       arready,
  output logic [spc_pkg::DATA_W-1:0] rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  logic                       rready
);
  function automatic logic hit(input logic [spc_pkg::ADDR_W-1:0] a,
                               input logic [spc_pkg::ADDR_W-1:0] off);
    return a[spc_pkg::ADDR_W-1:2] == off[spc_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [spc_pkg::ADDR_W-1:0] a);
    return hit(a, spc_pkg::OFF_PIN) || hit(a, spc_pkg::OFF_DIR) ||
           hit(a, spc_pkg::OFF_PULL) || hit(a, spc_pkg::OFF_IOC) ||
           hit(a, spc_pkg::OFF_CTRL);
  endfunction

  function automatic logic [spc_pkg::DATA_W-1:0] pad(
      input logic [spc_pkg::PIN_W-1:0] v);
    return {spc_pkg::UPPER_ZERO, v};
  endfunction

  logic [spc_pkg::PIN_W-1:0]  outLatch;
  logic [spc_pkg::PIN_W-1:0]  pinDirection;
  logic [spc_pkg::PIN_W-1:0]  pullupEnable;
  logic [spc_pkg::PIN_W-1:0]  changeIrqEnable;
  logic                       globalPullup;
  logic                       awHeld;
  logic                       wHeld;
  logic [spc_pkg::ADDR_W-1:0] wrAddr;
  logic [spc_pkg::DATA_W-1:0] wrData;
  logic                       wrStrb0;
  logic [spc_pkg::PIN_W-1:0]  syncPins;
  logic                       mismatch;

  // Handshakes and decode
  wire awHs     = awvalid && awready;
  wire wHs      = wvalid && wready;
  wire arHs     = arvalid && arready;
  wire doWrite  = awHeld && wHeld;
  wire wrEn     = doWrite && wrStrb0;
  wire wrPin    = wrEn && hit(wrAddr, spc_pkg::OFF_PIN);
  wire wrDir    = wrEn && hit(wrAddr, spc_pkg::OFF_DIR);
  wire wrPull   = wrEn && hit(wrAddr, spc_pkg::OFF_PULL);
  wire wrIoc    = wrEn && hit(wrAddr, spc_pkg::OFF_IOC);
  wire wrCtrl   = wrEn && hit(wrAddr, spc_pkg::OFF_CTRL);
  wire rdPin    = arHs && hit(araddr, spc_pkg::OFF_PIN);
  // read or write of pin value
  wire capture  = rdPin || (doWrite && hit(wrAddr, spc_pkg::OFF_PIN));
  wire clrFlag  = wrCtrl && wrData[spc_pkg::CTRL_FLAG_BIT];

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;

  // Forced bits
  wire [spc_pkg::PIN_W-1:0] xtalSel = crystalMode ? spc_pkg::CRYSTAL_MASK
                                                  : spc_pkg::NO_PINS;
  wire [spc_pkg::PIN_W-1:0] mclrSel = masterClearFunction
                                      ? spc_pkg::INPUT_ONLY_MASK
                                      : spc_pkg::NO_PINS;
  wire [spc_pkg::PIN_W-1:0] dirRead = pinDirection |
                                      spc_pkg::INPUT_ONLY_MASK | xtalSel;
  wire [spc_pkg::PIN_W-1:0] pullRead = pullupEnable | xtalSel;
  wire [spc_pkg::PIN_W-1:0] iocRead = changeIrqEnable | xtalSel;
  wire [spc_pkg::PIN_W-1:0] pinReadValue = syncPins & ~analogSelect &
                                           ~mclrSel;
  wire [spc_pkg::DATA_W-1:0] ctrlRead =
    pad({4'h0, globalPullup, portChangeFlag});

  wire [spc_pkg::DATA_W-1:0] rdMux =
    hit(araddr, spc_pkg::OFF_PIN)  ? pad(pinReadValue) :
    hit(araddr, spc_pkg::OFF_DIR)  ? pad(dirRead)      :
    hit(araddr, spc_pkg::OFF_PULL) ? pad(pullRead)     :
    hit(araddr, spc_pkg::OFF_IOC)  ? pad(iocRead)      :
    hit(araddr, spc_pkg::OFF_CTRL) ? ctrlRead          :
    {spc_pkg::DATA_W{1'b0}};

  assign pinOutEnN = dirRead;
  assign pinOut    = outLatch;
  assign pullupOn  = (pullupEnable & dirRead & ~xtalSel &
                      {spc_pkg::PIN_W{globalPullup}}) | mclrSel;
  assign portChangeWake = portChangeFlag;

  wire next_flag = mismatch || (portChangeFlag && !clrFlag);

  spc_sync u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (pinIn),
    .q    (syncPins)
  );

  // change during capture may be absorbed
  spc_change u_change (
    .clk      (clk),
    .nrst     (nrst),
    .pins     (syncPins),
    .enable   (changeIrqEnable),
    .capture  (capture),
    .mismatch (mismatch)
  );

  // Write channel holding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      wrAddr  <= '0;
      wrData  <= '0;
      wrStrb0 <= 1'b0;
    end else begin
      if (awHs) begin
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wHs) begin
        wHeld   <= 1'b1;
        wrData  <= wdata;
        wrStrb0 <= wstrb[0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= spc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= mapped(wrAddr) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= spc_pkg::RESP_OKAY;
    end else if (arHs) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= mapped(araddr) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outLatch <= spc_pkg::LATCH_RST;
    end else if (wrPin) begin
      outLatch <= wrData[spc_pkg::PIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinDirection    <= spc_pkg::DIR_RST;
      pullupEnable    <= spc_pkg::PULL_RST;
      changeIrqEnable <= spc_pkg::IOC_RST;
      globalPullup    <= spc_pkg::GPU_RST;
    end else if (warmReset) begin
      pinDirection    <= spc_pkg::DIR_RST;
      pullupEnable    <= spc_pkg::PULL_RST;
      changeIrqEnable <= spc_pkg::IOC_RST;
      globalPullup    <= spc_pkg::GPU_RST;
    end else begin
      if (wrDir) pinDirection <= wrData[spc_pkg::PIN_W-1:0];
      if (wrPull) pullupEnable <= wrData[spc_pkg::PIN_W-1:0];
      if (wrIoc) changeIrqEnable <= wrData[spc_pkg::PIN_W-1:0];
      if (wrCtrl) globalPullup <= wrData[spc_pkg::CTRL_GPU_BIT];
    end
  end

  // mismatch after warm reset sets flag again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      portChangeFlag <= 1'b0;
    end else if (warmReset) begin
      portChangeFlag <= mismatch;
    end else begin
      portChangeFlag <= next_flag;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_UPPER_ZERO: assert property (
    rvalid |-> rdata[spc_pkg::DATA_W-1:spc_pkg::PIN_W] == '0)
    else $error("upper read bits not zero");
  AST_PIN_READ: assert property (
    rdPin |=> rdata[spc_pkg::PIN_W-1:0] == $past(pinReadValue))
    else $error("pin read value wrong");
  AST_ANALOG_ZERO: assert property (
    rdPin |=> (rdata[spc_pkg::PIN_W-1:0] & $past(analogSelect)) == '0)
    else $error("analog pin read nonzero");
  AST_DIR_DRIVE: assert property (
    awHs && wHs && awaddr == spc_pkg::OFF_DIR && wstrb[0] && !wdata[0]
    && !warmReset |-> ##2 !pinOutEnN[0])
    else $error("output not driven after direction write");
  AST_DIR_READ: assert property (
    arHs && hit(araddr, spc_pkg::OFF_DIR) |=> rdata[3] &&
    (!$past(crystalMode) || rdata[5:4] == 2'h3))
    else $error("forced direction bits wrong");
  AST_PULL_OFF: assert property (
    (pullupOn & ~pinOutEnN) == '0)
    else $error("pull-up on driven pin");
  AST_PULL_GLOBAL: assert property (
    !globalPullup |-> pullupOn == mclrSel)
    else $error("pull-up on without global control");
  AST_MASTER_CLEAR_FUNCTION_PULL: assert property (
    masterClearFunction |-> pullupOn[3])
    else $error("master clear pull-up missing");
  AST_FLAG_SET: assert property (
    mismatch |=> portChangeFlag)
    else $error("mismatch did not set flag");
  AST_LATCH_END: assert property (
    capture ##1 $stable(syncPins) |-> !mismatch)
    else $error("access did not end mismatch");
  AST_BRESP_TIME: assert property (
    awHs && wHs |-> !bvalid ##1 !bvalid ##1 bvalid)
    else $error("write response timing wrong");
  AST_READ_TIME: assert property (
    arHs |=> rvalid && !arready)
    else $error("read response timing wrong");
  AST_INPUT_ONLY: assert property (
    &(pinOutEnN | ~spc_pkg::INPUT_ONLY_MASK))
    else $error("input-only pin driven");
  AST_XTAL_DRIVE: assert property (
    crystalMode |-> &(pinOutEnN | ~spc_pkg::CRYSTAL_MASK))
    else $error("crystal pin driven");
  AST_PULL_XTAL: assert property (
    arHs && crystalMode && hit(araddr, spc_pkg::OFF_PULL) |=>
    &(rdata[spc_pkg::PIN_W-1:0] | ~spc_pkg::CRYSTAL_MASK))
    else $error("crystal pull-up bits not forced");
  AST_IOC_XTAL: assert property (
    arHs && crystalMode && hit(araddr, spc_pkg::OFF_IOC) |=>
    &(rdata[spc_pkg::PIN_W-1:0] | ~spc_pkg::CRYSTAL_MASK))
    else $error("crystal change-enable bits not forced");
  AST_LATCH_WRITE: assert property (
    wrPin |=> pinOut == $past(wrData[spc_pkg::PIN_W-1:0]))
    else $error("output latch not loaded");
  AST_FLAG_CLEAR: assert property (
    clrFlag && !mismatch |=> !portChangeFlag)
    else $error("flag clear ignored");
  AST_FLAG_STICKY: assert property (
    portChangeFlag && !clrFlag && !warmReset |=> portChangeFlag)
    else $error("flag dropped without clear");
  AST_WARM_FLAG: assert property (
    warmReset |=> portChangeFlag == $past(mismatch))
    else $error("flag wrong after warm reset");

  COV_PIN_WRITE: cover property (wrPin);
  COV_PIN_READ:  cover property (rdPin ##1 rvalid);
  COV_FLAG:      cover property (mismatch ##1 portChangeFlag ##[1:20] clrFlag);
  COV_CRYSTAL:   cover property (crystalMode && arHs);
  COV_MASKED:    cover property (doWrite && !wrStrb0);
endmodule // spc_port

// ### test/spc_pin_model.sv
module spc_pin_model (
  // Clock
  input  logic                      clk,
  // Device side
  input  logic [spc_pkg::PIN_W-1:0] pinOut,
  input  logic [spc_pkg::PIN_W-1:0] pinOutEnN,
  input  logic [spc_pkg::PIN_W-1:0] pullupOn,
  // Board side
  input  logic [spc_pkg::PIN_W-1:0] extLevel,
  input  logic [spc_pkg::PIN_W-1:0] extEn,
  // Wire level
  output logic [spc_pkg::PIN_W-1:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [spc_pkg::PIN_W-1:0] floatLevel = 6'h15;

  // Undriven pin without pull-up wanders
  always @(posedge clk) begin
    floatLevel <= ~floatLevel;
  end

  assign pinLevel = (~pinOutEnN & pinOut)
                  | (pinOutEnN & extEn & extLevel)
                  | (pinOutEnN & ~extEn & pullupOn)
                  | (pinOutEnN & ~extEn & ~pullupOn & floatLevel);
endmodule // spc_pin_model

// ### test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        warmReset = 1'b0;
  logic        crystalMode = 1'b0;
  logic        masterClearFunction = 1'b0;
  logic [5:0]  analogSelect = 6'h00;
  logic [5:0]  extLevel = 6'h00;
  logic [5:0]  extEn = 6'h3f;
  logic [5:0]  pinLevel, pinOut, pinOutEnN, pullupOn;
  logic        portChangeFlag, portChangeWake;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [5:0]  v, d, p, q, c, e, m;
  logic        g, cry, mc;
  int          fails = 0;
  int          checks = 0;
  int          seed;

  always #25 clk = ~clk;

  spc_port spc_port_i (
    .clk, .nrst, .warmReset, .crystalMode, .masterClearFunction,
    .analogSelect, .pinIn(pinLevel), .pinOut, .pinOutEnN, .pullupOn,
    .portChangeFlag, .portChangeWake, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );
  spc_pin_model spc_pin_model_i (
    .clk, .pinOut, .pinOutEnN, .pullupOn, .extLevel, .extEn, .pinLevel
  );

  function automatic logic [5:0] cm(logic x);
    return x ? spc_pkg::CRYSTAL_MASK : 6'h00;
  endfunction
  function automatic logic [5:0] dirEff(logic [5:0] dd, logic cc);
    return dd | spc_pkg::INPUT_ONLY_MASK | cm(cc);
  endfunction
  function automatic logic [5:0] pullExp(logic [5:0] pp, dd,
                                         logic gg, cc, mm);
    return ({6{gg}} & pp & dirEff(dd, cc) & ~cm(cc)) | (mm ? 6'h08 : 6'h00);
  endfunction
  function automatic logic [5:0] lvlExp(logic [5:0] qq, de, en, x, pu);
    return (qq & ~de) | (de & en & x) | (de & ~en & pu);
  endfunction

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 100) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] dw,
                          input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dw;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clk);
      if (!aw && awready)
        aw = 1'b1;
      if (!w && wready)
        w = 1'b1;
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      tick(n);
    end
    do begin
      @(negedge clk);
      tick(n);
    end while (!bvalid);
    chk("bresp", 32'(bresp), 32'(er));
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] dr,
                         input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      tick(n);
    end while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      tick(n);
    end while (!rvalid);
    dr = rdata;
    chk("rresp", 32'(rresp), 32'(er));
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a,
                       input logic [5:0] ex);
    axiRead(a, rd, spc_pkg::RESP_OKAY);
    chk(nm, rd, 32'(ex));
  endtask
  task automatic wr(input logic [7:0] a, input logic [5:0] dw);
    axiWrite(a, 32'(dw), spc_pkg::RESP_OKAY);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    seed = $urandom(32'hfbe9d8bb);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdChk("dirRst", spc_pkg::OFF_DIR, 6'h3f);
    rdChk("iocRst", spc_pkg::OFF_IOC, 6'h00);
    rdChk("ctrlRst", spc_pkg::OFF_CTRL, 6'h00);
    chk("pullRst", 32'(pullupOn), 32'h0);
    // Pin reads with analog and master clear masking
    for (int i = 0; i < 8; i++) begin
      v = 6'($urandom);
      m = (i < 2) ? 6'h00 : 6'($urandom);
      @(posedge clk);
      extLevel <= v;
      analogSelect <= m;
      masterClearFunction <= i[0];
      settle();
      e = v & ~m & ~(i[0] ? 6'h08 : 6'h00);
      rdChk("pinValue", spc_pkg::OFF_PIN, e);
    end
    // Direction, pull-ups, crystal and master clear forcing
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 6'h00 : 6'($urandom);
      p = (i == 0) ? 6'h3f : 6'($urandom);
      g = (i == 0) ? 1'b1 : 1'($urandom);
      c = 6'($urandom);
      q = 6'($urandom);
      cry = i[1];
      mc = i[0];
      @(posedge clk);
      crystalMode <= cry;
      masterClearFunction <= mc;
      analogSelect <= 6'h00;
      extEn <= 6'($urandom);
      extLevel <= 6'($urandom);
      wr(spc_pkg::OFF_DIR, d);
      wr(spc_pkg::OFF_PULL, p);
      wr(spc_pkg::OFF_IOC, c);
      wr(spc_pkg::OFF_CTRL, {4'h0, g, 1'b0});
      wr(spc_pkg::OFF_PIN, q);
      rdChk("dir", spc_pkg::OFF_DIR, dirEff(d, cry));
      rdChk("pull", spc_pkg::OFF_PULL, p | cm(cry));
      rdChk("ioc", spc_pkg::OFF_IOC, c | cm(cry));
      settle();
      e = pullExp(p, d, g, cry, mc);
      chk("enN", 32'(pinOutEnN), 32'(dirEff(d, cry)));
      chk("pullupOn", 32'(pullupOn), 32'(e));
      chk("pinOut", 32'(pinOut), 32'(q));
      m = ~dirEff(d, cry) | extEn | e;
      v = lvlExp(q, dirEff(d, cry), extEn, extLevel, e) & ~(mc ? 6'h08 : 6'h00);
      axiRead(spc_pkg::OFF_PIN, rd, spc_pkg::RESP_OKAY);
      chk("pinLvl", rd & 32'(m), 32'(v & m));
    end
    // Change detection on every pin
    @(posedge clk);
    crystalMode <= 1'b0;
    masterClearFunction <= 1'b0;
    extEn <= 6'h3f;
    v = 6'($urandom);
    extLevel <= v;
    wr(spc_pkg::OFF_DIR, 6'h3f);
    wr(spc_pkg::OFF_IOC, 6'h3f);
    settle();
    for (int k = 0; k < 6; k++) begin
      axiRead(spc_pkg::OFF_PIN, rd, spc_pkg::RESP_OKAY);
      wr(spc_pkg::OFF_CTRL, 6'h01);
      @(negedge clk);
      chk("flagClr", 32'(portChangeFlag), 32'h0);
      @(posedge clk);
      v[k] = ~v[k];
      extLevel <= v;
      settle();
      chk("flagSet", 32'(portChangeFlag), 32'h1);
      chk("wake", 32'(portChangeWake), 32'h1);
      wr(spc_pkg::OFF_CTRL, 6'h01);
      @(negedge clk);
      chk("flagHold", 32'(portChangeFlag), 32'h1);
    end
    // Disabled pin raises nothing
    wr(spc_pkg::OFF_IOC, 6'h3e);
    axiRead(spc_pkg::OFF_PIN, rd, spc_pkg::RESP_OKAY);
    wr(spc_pkg::OFF_CTRL, 6'h01);
    @(posedge clk);
    extLevel <= v ^ 6'h01;
    settle();
    chk("flagOff", 32'(portChangeFlag), 32'h0);
    // Comparison latch kept over a warm reset
    @(posedge clk);
    extLevel <= 6'h04;
    settle();
    axiRead(spc_pkg::OFF_PIN, rd, spc_pkg::RESP_OKAY);
    wr(spc_pkg::OFF_IOC, 6'h00);
    @(posedge clk);
    extLevel <= 6'h00;
    settle();
    @(posedge clk);
    warmReset <= 1'b1;
    @(posedge clk);
    warmReset <= 1'b0;
    wr(spc_pkg::OFF_IOC, 6'h3f);
    wr(spc_pkg::OFF_CTRL, 6'h01);
    @(negedge clk);
    chk("flagWarm", 32'(portChangeFlag), 32'h1);
    // Masked writes keep registers, pin access still ends mismatch
    @(posedge clk);
    wstrb <= 4'he;
    wr(spc_pkg::OFF_PIN, 6'h2a);
    wr(spc_pkg::OFF_IOC, 6'h00);
    @(posedge clk);
    wstrb <= 4'hf;
    wr(spc_pkg::OFF_CTRL, 6'h01);
    @(negedge clk);
    chk("flagWrClr", 32'(portChangeFlag), 32'h0);
    chk("strbOut", 32'(pinOut), 32'(q));
    rdChk("strbIoc", spc_pkg::OFF_IOC, 6'h3f);
    // Unmapped addresses
    axiRead(8'h14, rd, spc_pkg::RESP_SLVERR);
    axiWrite(8'h20, 32'h0, spc_pkg::RESP_SLVERR);
    complete_run();
  end
endmodule // tb
